// ==== rtl/bus_sync3.sv ====
`timescale 1ns/1ns
module bus_sync3 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // ********************************
  // three stages, change once 2 and 3 agree
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // bus_sync3

// ==== rtl/io_bus_if.sv ====
`timescale 1ns/1ns
interface io_bus_if;
  logic [io_vec_pkg::DEV_W-1:0] dev_addr;
  logic                         addr_valid;
  logic [7:0]                   cmd;
  logic                         cmd_valid;
  logic [io_vec_pkg::LVL_N-1:0] ack;
  logic [io_vec_pkg::LVL_N-1:0] attn;
  logic                         sync;
  logic [io_vec_pkg::DEV_W-1:0] resp_dev;
  logic [7:0]                   status;
  logic                         ack_priority_chain;
  modport proc (output dev_addr, addr_valid, cmd, cmd_valid, ack,
                input attn, sync, resp_dev, status, ack_priority_chain);
  modport ctl  (input dev_addr, addr_valid, cmd, cmd_valid, ack,
                output attn, sync, resp_dev, status, ack_priority_chain);
endinterface

// ==== rtl/io_dev_ctl.sv ====
`timescale 1ns/1ns
module io_dev_ctl
  import io_vec_pkg::*;
#(
  parameter logic [io_vec_pkg::DEV_W-1:0] MY_DEV = 10'h001,
  parameter int                           LEVEL  = 0
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  io_bus_if.ctl            bus,
  input  wire logic        req,
  input  wire logic [7:0]  dev_status,
  output logic      [7:0]  cmd_byte,
  output logic             cmd_strobe,
  output logic             pending
);
  logic [2:0] in_s;
  logic       addr_s;
  logic       cmdv_s;
  logic       ack_s;
  logic       cmdv_q;
  logic       capt_q;
  logic       sel_q;
  logic       sync_q;
  logic       chain_q;
  logic [7:0] stat_q;
  logic [DEV_W-1:0] resp_q;

  bus_sync3 #(.W(3)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({bus.addr_valid, bus.cmd_valid, bus.ack[LEVEL]}),
    .q    (in_s)
  );
  assign addr_s = in_s[2];
  assign cmdv_s = in_s[1];
  assign ack_s  = in_s[0];

  assign bus.sync               = sync_q;
  assign bus.resp_dev           = resp_q;
  assign bus.status             = stat_q;
  assign bus.ack_priority_chain = chain_q;
  assign bus.attn               = pending ? (LVL_N)'(1 << LEVEL) : '0;

  // ********************************
  // attention request and chain capture
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pending <= 1'b0;
      capt_q  <= 1'b0;
      chain_q <= 1'b0;
    end
    else
    begin
      chain_q <= ack_s && !pending;
      if (ack_s && pending)
      begin
        capt_q <= 1'b1;
      end
      else if (!ack_s && capt_q)
      begin
        capt_q  <= 1'b0;
        pending <= 1'b0;
      end
      if (req)
      begin
        pending <= 1'b1;
      end
    end
  end

  // ********************************
  // sync, number and status answers
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_q <= 1'b0;
      sel_q  <= 1'b0;
      resp_q <= '0;
      stat_q <= '0;
    end
    else
    begin
      stat_q <= dev_status;
      sel_q  <= addr_s && bus.dev_addr == MY_DEV && MY_DEV != '0;
      resp_q <= MY_DEV;
      sync_q <= (addr_s && bus.dev_addr == MY_DEV && MY_DEV != '0) || (ack_s && pending) || (ack_s && capt_q);
    end
  end

  // ********************************
  // command byte on rising command valid
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmdv_q     <= 1'b0;
      cmd_byte   <= '0;
      cmd_strobe <= 1'b0;
    end
    else
    begin
      cmdv_q     <= cmdv_s;
      cmd_strobe <= sel_q && cmdv_s && !cmdv_q;
      if (sel_q && cmdv_s && !cmdv_q)
      begin
        cmd_byte <= bus.cmd;
      end
    end
  end
endmodule // io_dev_ctl

// ==== rtl/io_proc_end.sv ====
`timescale 1ns/1ns
module io_proc_end
  import io_vec_pkg::*;
#(
  parameter int DEV_BITS = 10
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  io_bus_if.proc           bus,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        insn_boundary,
  output logic             mem_req,
  output logic [23:0]      mem_addr,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             int_taken,
  output logic             adc_req,
  output logic [io_vec_pkg::DEV_W-1:0] adc_dev
);
  localparam int                CW       = $clog2(TOUT_CYC + 1);
  localparam logic [CW-1:0]     TOUT_END = CW'(TOUT_CYC - 1);
  localparam logic [CW-1:0]     HOLD_END = CW'(CMD_HOLD_CYC - 1);
  localparam logic [DEV_W-1:0]  DEV_MASK = DEV_W'((1 << DEV_BITS) - 1);

  proc_state_t      state_q;
  logic [CW-1:0]    cnt_q;
  logic [4:0]       in_s;
  logic [3:0]       attn_s;
  logic             sync_s;
  logic [3:0]       lvl_en;
  logic [3:0]       pend;
  logic [1:0]       grant;
  logic [1:0]       lvl_q;
  logic [31:0]      psw_q;
  logic [31:0]      loc_q;
  logic [31:0]      save_q [4];
  logic [DEV_W-1:0] dev_q;
  logic [7:0]       stat_q;
  logic [15:0]      entry_q;
  logic             busy_err_q;
  logic             tout_q;
  logic             priv_q;
  logic             imm_q;
  logic             adc_q;
  logic [7:0]       aw_q;
  logic             aw_have_q;
  logic [31:0]      w_q;
  logic [3:0]       ws_q;
  logic             w_have_q;
  logic             do_wr;
  logic             wr_ok;
  logic [31:0]      rd_d;
  logic             rd_ok;
  logic             start;
  logic             tout_evt;
  logic             fetch_done;

  bus_sync3 #(.W(5)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({bus.sync, bus.attn}),
    .q    (in_s)
  );
  assign attn_s = in_s[3:0];
  assign sync_s = in_s[4];

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
      begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ********************************
  // level enables and priority
  // ********************************
  for (genvar l = 0; l < LVL_N; l++)
  begin : g_lvl
    assign lvl_en[l] = psw_q[PSW_IO_EN] && (psw_q[PSW_ALL_EN] || 4'(l) < psw_q[7:4]);
  end
  assign pend = attn_s & lvl_en;

  always_comb
  begin
    grant = 2'd0;
    for (int l = LVL_N - 1; l >= 0; l--)
    begin
      if (pend[l])
      begin
        grant = 2'(l);
      end
    end
  end

  assign do_wr      = aw_have_q && w_have_q && !bvalid;
  assign start      = do_wr && aw_q == OFS_CMD && state_q == S_IDLE && !psw_q[PSW_PROB];
  assign tout_evt   = (state_q == S_ADDR || state_q == S_ACK) && !sync_s && cnt_q == TOUT_END;
  assign fetch_done = state_q == S_FETCH && mem_ack;
  assign wr_ok      = aw_q == OFS_PSW || aw_q == OFS_CMD || aw_q == OFS_STAT || aw_q == OFS_LOC;

  // ********************************
  // bus sequencer
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q        <= S_IDLE;
      cnt_q          <= '0;
      bus.dev_addr   <= '0;
      bus.addr_valid <= 1'b0;
      bus.cmd        <= '0;
      bus.cmd_valid  <= 1'b0;
      bus.ack        <= '0;
      lvl_q          <= '0;
      dev_q          <= '0;
      stat_q         <= '0;
      entry_q        <= '0;
      mem_req        <= 1'b0;
      mem_addr       <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      unique case (state_q)
        S_IDLE:
        begin
          cnt_q <= '0;
          if (start)
          begin
            bus.dev_addr   <= w_q[DEV_W-1:0] & DEV_MASK;
            bus.cmd        <= w_q[17:10];
            bus.addr_valid <= 1'b1;
            state_q        <= S_ADDR;
          end
          else if (insn_boundary && pend != '0)
          begin
            lvl_q        <= grant;
            bus.ack      <= 4'(1 << grant);
            state_q      <= S_ACK;
          end
        end
        S_ADDR:
        begin
          if (sync_s)
          begin
            stat_q        <= bus.status;
            bus.cmd_valid <= 1'b1;
            cnt_q         <= '0;
            state_q       <= S_CMD;
          end
          else if (tout_evt)
          begin
            bus.addr_valid <= 1'b0;
            stat_q         <= FALSE_SYNC;
            state_q        <= S_IDLE;
          end
        end
        S_CMD:
        begin
          if (cnt_q == HOLD_END)
          begin
            bus.addr_valid <= 1'b0;
            bus.cmd_valid  <= 1'b0;
            state_q        <= S_REL;
          end
        end
        S_REL:
        begin
          if (!sync_s)
          begin
            state_q <= S_IDLE;
          end
        end
        S_ACK:
        begin
          if (sync_s)
          begin
            dev_q    <= bus.resp_dev & DEV_MASK;
            stat_q   <= bus.status;
            bus.ack  <= '0;
            mem_req  <= 1'b1;
            mem_addr <= TABLE_BASE + 24'({bus.resp_dev & DEV_MASK, 1'b0});
            state_q  <= S_FETCH;
          end
          else if (tout_evt)
          begin
            bus.ack <= '0;
            state_q <= S_IDLE;
          end
        end
        S_FETCH:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            entry_q <= mem_rdata;
            state_q <= S_REL;
          end
        end
      endcase
    end
  end

  // ********************************
  // status word, counter and save area
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      psw_q     <= PSW_RST;
      loc_q     <= '0;
      save_q    <= '{default: '0};
      int_taken <= 1'b0;
      adc_req   <= 1'b0;
      adc_dev   <= '0;
    end
    else
    begin
      int_taken <= 1'b0;
      adc_req   <= 1'b0;
      if (fetch_done && !mem_rdata[ENTRY_ADC])
      begin
        save_q[0] <= psw_q;
        save_q[1] <= loc_q;
        save_q[2] <= 32'(dev_q);
        save_q[3] <= 32'(stat_q);
        psw_q     <= {NEW_STAT_HI, NEW_STAT_MID, {2'b00, lvl_q}, stat_q[3:0]};
        loc_q     <= 32'(mem_rdata);
        int_taken <= 1'b1;
      end
      else if (fetch_done)
      begin
        adc_req <= 1'b1;
        adc_dev <= dev_q;
      end
      else if (tout_evt && state_q == S_ADDR)
      begin
        psw_q[3:0] <= CC_V;
      end
      else if (state_q == S_ADDR && sync_s)
      begin
        psw_q[3:0] <= bus.status[3:0];
      end
      else if (do_wr && aw_q == OFS_PSW)
      begin
        psw_q <= merge(psw_q, w_q, ws_q);
      end
      else if (do_wr && aw_q == OFS_LOC)
      begin
        loc_q <= merge(loc_q, w_q, ws_q);
      end
    end
  end

  // ********************************
  // sticky flags, set wins over clear
  // ********************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tout_q     <= 1'b0;
      priv_q     <= 1'b0;
      busy_err_q <= 1'b0;
      imm_q      <= 1'b0;
      adc_q      <= 1'b0;
    end
    else
    begin
      if (do_wr && aw_q == OFS_STAT)
      begin
        tout_q     <= tout_q & ~w_q[1];
        priv_q     <= priv_q & ~w_q[2];
        busy_err_q <= busy_err_q & ~w_q[3];
        imm_q      <= imm_q & ~w_q[4];
        adc_q      <= adc_q & ~w_q[5];
      end
      if (tout_evt)
      begin
        tout_q <= 1'b1;
      end
      if (do_wr && aw_q == OFS_CMD && psw_q[PSW_PROB])
      begin
        priv_q <= 1'b1;
      end
      if (do_wr && aw_q == OFS_CMD && !psw_q[PSW_PROB] && state_q != S_IDLE)
      begin
        busy_err_q <= 1'b1;
      end
      if (fetch_done)
      begin
        imm_q <= imm_q | !mem_rdata[ENTRY_ADC];
        adc_q <= adc_q | mem_rdata[ENTRY_ADC];
      end
    end
  end

  // ********************************
  // register bus slave
  // ********************************
  always_comb
  begin
    rd_ok = 1'b1;
    rd_d  = '0;
    unique case (araddr)
      OFS_PSW:   rd_d = psw_q;
      OFS_STAT:  rd_d = {6'd0, dev_q, stat_q, 2'd0, adc_q, imm_q, busy_err_q, priv_q, tout_q, state_q != S_IDLE};
      OFS_LOC:   rd_d = loc_q;
      OFS_SAVE0: rd_d = save_q[0];
      OFS_SAVE1: rd_d = save_q[1];
      OFS_SAVE2: rd_d = save_q[2];
      OFS_SAVE3: rd_d = save_q[3];
      OFS_VEC:   rd_d = {16'd0, entry_q};
      default:   rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_q      <= '0;
      aw_have_q <= 1'b0;
      awready   <= 1'b0;
      w_q       <= '0;
      ws_q      <= '0;
      w_have_q  <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OK;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= '0;
      rresp     <= RESP_OK;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_q      <= awaddr;
        aw_have_q <= 1'b1;
      end
      if (wvalid && wready)
      begin
        w_q      <= wdata;
        ws_q     <= wstrb;
        w_have_q <= 1'b1;
      end
      awready <= do_wr || !(aw_have_q || (awvalid && awready));
      wready  <= do_wr || !(w_have_q || (wvalid && wready));
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? RESP_OK : RESP_SLVERR;
      end
      else if (bready)
      begin
        bvalid <= 1'b0;
      end
      arready <= !(arvalid && arready) && (!rvalid || rready);
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_d;
        rresp  <= rd_ok ? RESP_OK : RESP_SLVERR;
      end
      else if (rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // io_proc_end

// ==== rtl/io_vec_pkg.sv ====
package io_vec_pkg;
  localparam int          DEV_W        = 10;
  localparam int          LVL_N        = 4;
  localparam int          CLK_NS       = 100;
  localparam int          TOUT_NS      = 28000;
  localparam int          TOUT_CYC     = TOUT_NS / CLK_NS;
  localparam int          CMD_HOLD_CYC = 4;
  localparam logic [23:0] TABLE_BASE   = 24'h0000D0;
  localparam logic [7:0]  FALSE_SYNC   = 8'h04;
  localparam logic [3:0]  CC_V         = 4'h4;
  localparam logic [15:0] NEW_STAT_HI  = 16'h0000;
  localparam logic [7:0]  NEW_STAT_MID = 8'h28;
  localparam int          PSW_ALL_EN   = 14;
  localparam int          PSW_IO_EN    = 11;
  localparam int          PSW_PROB     = 8;
  localparam int          ENTRY_ADC    = 0;
  localparam logic [31:0] PSW_RST      = 32'h0000_0000;
  localparam logic [7:0]  OFS_PSW      = 8'h00;
  localparam logic [7:0]  OFS_CMD      = 8'h04;
  localparam logic [7:0]  OFS_STAT     = 8'h08;
  localparam logic [7:0]  OFS_LOC      = 8'h0C;
  localparam logic [7:0]  OFS_SAVE0    = 8'h10;
  localparam logic [7:0]  OFS_SAVE1    = 8'h14;
  localparam logic [7:0]  OFS_SAVE2    = 8'h18;
  localparam logic [7:0]  OFS_SAVE3    = 8'h1C;
  localparam logic [7:0]  OFS_VEC      = 8'h20;
  localparam logic [1:0]  RESP_OK      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_REL, S_ACK, S_FETCH} proc_state_t;
endpackage

// ==== tb/io_vec_assertions.sv ====
`timescale 1ns/1ns
module io_vec_checker (
  input wire logic                         mclk,
  input wire logic                         nrst,
  input wire logic [io_vec_pkg::DEV_W-1:0] dev_addr,
  input wire logic                         addr_valid,
  input wire logic [7:0]                   cmd,
  input wire logic                         cmd_valid,
  input wire logic [io_vec_pkg::LVL_N-1:0] ack,
  input wire logic [io_vec_pkg::LVL_N-1:0] attn,
  input wire logic                         sync,
  input wire logic [io_vec_pkg::DEV_W-1:0] resp_dev,
  input wire logic [7:0]                   status,
  input wire logic                         ack_priority_chain
);
  import io_vec_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // link sequences
  // ****************************************
  sequence s_cmd_four;
    cmd_valid [*4] ##1 !cmd_valid;
  endsequence
  sequence s_addr_end;
    addr_valid ##[1:290] !addr_valid;
  endsequence
  // ****************************************
  // link properties
  // ****************************************
  a_ack_onehot: assert property ($onehot0(ack)) else $error("ack has several levels");
  a_ack_lowest: assert property ($rose(|ack) |-> ack == ($past(attn) & (~$past(attn) + 4'h1)))
    else $error("ack not on lowest pending level");
  a_ack_hold: assert property ($rose(|ack) |=> $stable(ack) [*3]) else $error("ack dropped early");
  a_ack_sync: assert property ($rose(|ack) |-> ##[1:12] sync) else $error("no sync after ack");
  a_sync_cause: assert property ($rose(sync) |-> (|ack) || (addr_valid && dev_addr == resp_dev))
    else $error("sync without cause");
  a_cmd_burst: assert property ($rose(cmd_valid) |-> sync && addr_valid ##0 s_cmd_four)
    else $error("command burst wrong");
  a_addr_bound: assert property ($rose(addr_valid) |-> s_addr_end) else $error("address never released");
  a_addr_hold: assert property (addr_valid && $past(addr_valid) |-> $stable(dev_addr) && $stable(cmd))
    else $error("address moved in exchange");
  a_ack_apart: assert property (|ack |-> !addr_valid) else $error("ack during exchange");
  a_sync_free: assert property ($fell(addr_valid) |-> ##[1:10] !sync) else $error("sync stuck");
endmodule // io_vec_checker

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import io_vec_pkg::*;
  logic        mclk, nrst;
  logic [7:0]  awaddr = '0, araddr = '0, dev_status = '0, cmd_byte;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1, insn_boundary = 0;
  logic        awready, wready, bvalid, arready, rvalid, mem_req, int_taken, adc_req, cmd_strobe, pending;
  logic [1:0]  bresp, rresp;
  logic [23:0] mem_addr, last_maddr = '0;
  logic [15:0] mem_rdata = '0, entry = '0;
  logic        mem_ack = 0, req = 0, ack_q = 0;
  logic [DEV_W-1:0] adc_dev;
  int          error_cnt = 0, n_compared = 0, run_len = 0, last_len = 0, av_n = 0, ack_n = 0;
  int          int_cnt = 0, adc_cnt = 0, strobe_n = 0;
  io_bus_if bus ();
  io_proc_end #(.DEV_BITS(10)) io_proc_end_i (.mclk, .nrst, .bus(bus), .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .insn_boundary, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .int_taken,
    .adc_req, .adc_dev);
  io_dev_ctl #(.MY_DEV(10'h001), .LEVEL(0)) io_dev_ctl_i (.mclk, .nrst, .bus(bus), .req, .dev_status,
    .cmd_byte, .cmd_strobe, .pending);
  io_vec_checker io_vec_checker_i (.mclk, .nrst, .dev_addr(bus.dev_addr), .addr_valid(bus.addr_valid),
    .cmd(bus.cmd), .cmd_valid(bus.cmd_valid), .ack(bus.ack), .attn(bus.attn), .sync(bus.sync),
    .resp_dev(bus.resp_dev), .status(bus.status), .ack_priority_chain(bus.ack_priority_chain));
  // ****************************************
  // clock, monitors, table memory
  // ****************************************
  initial
  begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    run_len <= bus.addr_valid ? run_len + 1 : 0;
    if (!bus.addr_valid && run_len != 0) last_len <= run_len;
    if (bus.addr_valid && run_len == 0) av_n <= av_n + 1;
    if (|bus.ack && !ack_q) ack_n <= ack_n + 1;
    ack_q <= |bus.ack;
    if (int_taken) int_cnt <= int_cnt + 1;
    if (adc_req) adc_cnt <= adc_cnt + 1;
    if (cmd_strobe) strobe_n <= strobe_n + 1;
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= entry;
    if (mem_req) last_maddr <= mem_addr;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er), "write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    chk(32'(rresp), 32'(er), "read response");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                        input logic [1:0] er, input string what);
    logic [31:0] d;
    axi_rd(a, d, er);
    chk(d & m, exp, what);
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int n = 0; n < 400 && s[0] !== 1'b0; n++) axi_rd(OFS_STAT, s, RESP_OK);
  endtask
  task automatic wait_chg(ref int c, input int v);
    for (int n = 0; n < 500 && c == v; n++) @(posedge mclk);
    chk(32'(c != v), 32'h1, "event seen");
  endtask
  task automatic pulse_req();
    @(posedge mclk);
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    int k;
    int j;
    nrst = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(OFS_PSW, PSW_RST, '1, RESP_OK, "psw reset");
    rd_chk(8'h24, 32'h0, '1, RESP_SLVERR, "unmapped read");
    axi_wr(OFS_SAVE0, 32'h1, RESP_SLVERR);
    axi_wr(OFS_LOC, 32'h1234, RESP_OK);
    rd_chk(OFS_LOC, 32'h1234, '1, RESP_OK, "loc");
    $display("test registers done");
    dev_status <= 8'hA5;
    axi_wr(OFS_CMD, {14'h0, 8'h3C, 10'h001}, RESP_OK);
    wait_idle();
    rd_chk(OFS_STAT, 32'h0000A500, 32'h0000FF0F, RESP_OK, "exchange stat");
    rd_chk(OFS_PSW, 32'h5, '1, RESP_OK, "exchange cc");
    chk(32'(cmd_byte), 32'h3C, "command byte");
    chk(strobe_n, 1, "one strobe");
    $display("test exchange done");
    axi_wr(OFS_PSW, 32'h0, RESP_OK);
    axi_wr(OFS_CMD, 32'h3FF, RESP_OK);
    axi_wr(OFS_CMD, 32'h3FF, RESP_OK);
    wait_idle();
    rd_chk(OFS_STAT, 32'h0000040A, 32'h0000FF0F, RESP_OK, "timeout stat");
    rd_chk(OFS_PSW, 32'h4, '1, RESP_OK, "timeout cc");
    chk(32'(last_len >= TOUT_CYC && last_len <= TOUT_CYC + 2), 32'h1, "timeout span");
    axi_wr(OFS_STAT, 32'h3E, RESP_OK);
    rd_chk(OFS_STAT, 32'h0, 32'h3E, RESP_OK, "stat clear");
    $display("test timeout done");
    axi_wr(OFS_CMD, 32'h400, RESP_OK);
    wait_idle();
    rd_chk(OFS_STAT, 32'h00000402, 32'h0000FF0F, RESP_OK, "device zero unanswered");
    chk(strobe_n, 1, "no command at device zero");
    $display("test device zero done");
    axi_wr(OFS_PSW, 32'h100, RESP_OK);
    k = av_n;
    axi_wr(OFS_CMD, 32'h001, RESP_OK);
    repeat (20) @(posedge mclk);
    chk(av_n, k, "no exchange in problem state");
    rd_chk(OFS_STAT, 32'h4, 32'h4, RESP_OK, "privilege flag");
    $display("test privilege done");
    axi_wr(OFS_PSW, 32'h0, RESP_OK);
    entry = 16'h3000;
    dev_status <= 8'h9C;
    pulse_req();
    repeat (30) @(posedge mclk);
    chk(ack_n, 0, "masked attention");
    axi_wr(OFS_PSW, 32'h4800, RESP_OK);
    repeat (30) @(posedge mclk);
    chk(ack_n, 0, "no boundary");
    k = int_cnt;
    insn_boundary <= 1'b1;
    wait_chg(int_cnt, k);
    chk(ack_n, 1, "one ack");
    chk(32'(last_maddr), 32'(TABLE_BASE) + 32'h2, "table address");
    rd_chk(OFS_SAVE0, 32'h4800, '1, RESP_OK, "old psw");
    rd_chk(OFS_SAVE1, 32'h1234, '1, RESP_OK, "old loc");
    rd_chk(OFS_SAVE2, 32'h1, '1, RESP_OK, "saved number");
    rd_chk(OFS_SAVE3, 32'h9C, '1, RESP_OK, "saved status");
    rd_chk(OFS_PSW, 32'h0000280C, '1, RESP_OK, "new psw");
    rd_chk(OFS_LOC, 32'h3000, '1, RESP_OK, "new loc");
    rd_chk(OFS_STAT, 32'h00010010, 32'h03FF0010, RESP_OK, "taken stat");
    $display("test interrupt done");
    for (int n = 0; n < 100 && (pending !== 1'b0 || bus.sync !== 1'b0); n++) @(posedge mclk);
    entry = 16'h3001;
    axi_wr(OFS_PSW, 32'h4800, RESP_OK);
    k = adc_cnt;
    j = int_cnt;
    pulse_req();
    wait_chg(adc_cnt, k);
    chk(32'(adc_dev), 32'h1, "channel number");
    chk(int_cnt, j, "no interrupt");
    rd_chk(OFS_LOC, 32'h3000, '1, RESP_OK, "loc kept");
    $display("test channel done");
    close_out();
  end
endmodule // tb_top
